// [design/mpt_timers.sv]
// Transmit pacing counter, receive and transmit pause timers, register port.
// Assumes all event inputs come from MAC logic on the same clock.
`timescale 1ns/1ps

module mpt_timers #(
  parameter int SLOT_CYCLES = mpt_pkg::SLOT_CYCLES,
  parameter int IPG_CYCLES  = mpt_pkg::IPG_CYCLES,
  parameter int GAP_W       = 8
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire mpt_pkg::mpt_bus_req_t  bus,
  output logic [31:0]                 rdata,
  input  wire mpt_pkg::mpt_tx_end_t   tx_end,
  input  wire mpt_pkg::mpt_pause_rx_t pause_rx,
  input  wire logic                   pause_sent,
  input  wire logic                   flow_active,
  output logic                        pause_resend,
  output logic                        tx_enable,
  output logic                        pacing_active
);

  localparam logic [GAP_W-1:0] GAP_ONE  = GAP_W'(IPG_CYCLES);
  localparam logic [GAP_W-1:0] GAP_FOUR = GAP_W'(IPG_CYCLES * mpt_pkg::PACE_GAP_MULT);
  localparam logic [15:0]      SLOT_END = 16'(SLOT_CYCLES - 1);

  logic [4:0]       pace_q;
  logic [15:0]      rxp_q;
  logic [15:0]      txp_q;
  logic             test_q;
  logic             armed_q;
  logic [15:0]      slot_q;
  logic [GAP_W-1:0] gap_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             tick;
  logic             clean;
  logic             dirty;
  logic             wr_pace;
  logic             wr_rxp;
  logic             wr_txp;
  logic             wr_ctrl;
  logic             resend;

  // Saturating decrement shared by the pacing counter and both pause timers.
  function automatic logic [15:0] sat_dec(input logic [15:0] v);
    sat_dec = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction

  assign clean   = tx_end.done && !tx_end.collided && !tx_end.deferred;
  assign dirty   = tx_end.done && (tx_end.collided || tx_end.deferred);
  assign wr_pace = bus.wr && (bus.addr == mpt_pkg::PACE_OFS);
  assign wr_rxp  = bus.wr && (bus.addr == mpt_pkg::RXP_OFS) && test_q;
  assign wr_txp  = bus.wr && (bus.addr == mpt_pkg::TXP_OFS) && test_q;
  assign wr_ctrl = bus.wr && (bus.addr == mpt_pkg::CTRL_OFS);
  assign resend  = (rxp_q == 16'h0000) && armed_q && flow_active;

  // Slot time divider gives a one-cycle tick.
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_q <= 16'h0000;
    end else if (slot_q == SLOT_END) begin
      slot_q <= 16'h0000;
    end else begin
      slot_q <= slot_q + 16'h0001;
    end
  end
  assign tick = (slot_q == SLOT_END);

  // Control register with the test mode enable bit.
  always_ff @(posedge clk) begin
    if (reset) begin
      test_q <= mpt_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      test_q <= bus.wdata[mpt_pkg::TEST_BIT];
    end
  end

  // Pacing counter; frame events win over a register write.
  always_ff @(posedge clk) begin
    if (reset) begin
      pace_q <= mpt_pkg::PACE_RST;
    end else if (dirty) begin
      pace_q <= mpt_pkg::PACE_MAX;
    end else if (clean) begin
      pace_q <= 5'(sat_dec({11'h000, pace_q}));
    end else if (wr_pace) begin
      pace_q <= bus.wdata[mpt_pkg::PACE_LSB +: mpt_pkg::PACE_W];
    end
  end
  assign pacing_active = (pace_q != 5'h00);

  // Inter-packet gap counter, stretched fourfold after a clean frame while pacing.
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_q <= '0;
    end else if (clean && pacing_active) begin
      gap_q <= GAP_FOUR;
    end else if (tx_end.done) begin
      gap_q <= GAP_ONE;
    end else if (gap_q != '0) begin
      gap_q <= gap_q - GAP_W'(1);
    end
  end

  // Receive pause timer: loaded on a sent pause frame, resent at zero while the repeat flag is set and flow_active is high.
  always_ff @(posedge clk) begin
    if (reset) begin
      rxp_q <= mpt_pkg::PAUSE_RST;
    end else if (pause_sent || resend) begin
      rxp_q <= mpt_pkg::RXP_RELOAD;
    end else if (wr_rxp) begin
      rxp_q <= bus.wdata[mpt_pkg::PAUSE_LSB +: mpt_pkg::PAUSE_W];
    end else if (tick) begin
      rxp_q <= sat_dec(rxp_q);
    end
  end

  // Repeat flag stays set while flow control remains wanted.
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else if (pause_sent) begin
      armed_q <= 1'b1;
    end else if (!flow_active) begin
      armed_q <= 1'b0;
    end
  end
  assign pause_resend = resend;

  // Transmit pause timer: loaded by an incoming pause frame.
  always_ff @(posedge clk) begin
    if (reset) begin
      txp_q <= mpt_pkg::PAUSE_RST;
    end else if (pause_rx.valid) begin
      txp_q <= pause_rx.quanta;
    end else if (wr_txp) begin
      txp_q <= bus.wdata[mpt_pkg::PAUSE_LSB +: mpt_pkg::PAUSE_W];
    end else if (tick) begin
      txp_q <= sat_dec(txp_q);
    end
  end
  assign tx_enable = (txp_q == 16'h0000) && (gap_q == '0);

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (bus.addr)
      mpt_pkg::PACE_OFS: rdata_d = {27'h000_0000, pace_q};
      mpt_pkg::RXP_OFS:  rdata_d = {16'h0000, rxp_q};
      mpt_pkg::TXP_OFS:  rdata_d = {16'h0000, txp_q};
      mpt_pkg::CTRL_OFS: rdata_d = {31'h0000_0000, test_q};
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= mpt_pkg::RDATA_RST;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= mpt_pkg::RDATA_RST;
    end
  end
  assign rdata = rdata_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence clean_paced_s;
    clean && pacing_active;
  endsequence

  sequence gap_runs_s;
    (!tx_end.done) [*2];
  endsequence

  sequence pause_in_s;
    pause_rx.valid && (pause_rx.quanta != 16'h0000);
  endsequence

  pace_load_a: assert property (
    dirty |=> (pace_q == 5'h1F))
    else $error("Pacing count not loaded after collision or deferral.");

  pace_dec_a: assert property (
    (clean && pace_q != 5'h00) |=> (pace_q == $past(pace_q) - 5'h01))
    else $error("Pacing count not lowered after clean frame.");

  pace_floor_a: assert property (
    (clean && pace_q == 5'h00 && !wr_pace) |=> (pace_q == 5'h00))
    else $error("Pacing count wrapped below zero.");

  stretch_gap_a: assert property (
    clean_paced_s ##1 gap_runs_s |-> (gap_q == GAP_FOUR - GAP_W'(1)) && !tx_enable)
    else $error("Gap after clean paced frame not stretched fourfold.");

  normal_gap_a: assert property (
    dirty |=> (gap_q == GAP_ONE))
    else $error("Gap after collided or deferred frame not normal.");

  pace_read_a: assert property (
    (bus.rd && bus.addr == mpt_pkg::PACE_OFS)
      |=> (rdata == {27'h000_0000, $past(pace_q)}))
    else $error("Pacing register read returned wrong value.");

  upper_zero_a: assert property (
    (bus.rd && bus.addr != mpt_pkg::PACE_OFS && bus.addr != mpt_pkg::CTRL_OFS)
      |=> (rdata[31:16] == 16'h0000))
    else $error("Reserved timer bits read nonzero.");

  rxp_load_a: assert property (
    pause_sent |=> (rxp_q == 16'hFF00) ##1 (rxp_q >= 16'hFEFF))
    else $error("Receive pause timer not loaded with FF00.");

  rxp_dec_a: assert property (
    (tick && rxp_q != 16'h0000 && !pause_sent && !wr_rxp)
      |=> (rxp_q == $past(rxp_q) - 16'h0001))
    else $error("Receive pause timer missed a slot decrement.");

  rxp_hold_a: assert property (
    (!tick && !pause_sent && !wr_rxp && !resend) |=> $stable(rxp_q))
    else $error("Receive pause timer moved between slots.");

  resend_a: assert property (
    (rxp_q == 16'h0000 && armed_q && flow_active)
      |-> pause_resend ##1 (rxp_q == 16'hFF00))
    else $error("No pause resend and reload at zero.");

  txp_load_a: assert property (
    pause_rx.valid |=> (txp_q == $past(pause_rx.quanta)))
    else $error("Transmit pause timer not loaded from pause frame.");

  tx_hold_a: assert property (
    pause_in_s |=> !tx_enable [*2])
    else $error("Transmission not held off during pause.");

  txp_dec_a: assert property (
    (tick && txp_q != 16'h0000 && !pause_rx.valid && !wr_txp)
      |=> (txp_q == $past(txp_q) - 16'h0001))
    else $error("Transmit pause timer missed a slot decrement.");

  locked_write_a: assert property (
    (!test_q && bus.wr && bus.addr == mpt_pkg::TXP_OFS && !pause_rx.valid && !tick)
      |=> $stable(txp_q))
    else $error("Transmit pause timer written outside test mode.");

  test_write_a: assert property (
    (test_q && bus.wr && bus.addr == mpt_pkg::RXP_OFS && !pause_sent && !resend)
      |=> (rxp_q == $past(bus.wdata[15:0])))
    else $error("Test mode write to receive pause timer lost.");

  sequence txp_last_tick_s;
    tick && (txp_q == 16'h0001) && !pause_rx.valid && !wr_txp
      && (gap_q == '0) && !tx_end.done;
  endsequence

  rdata_idle_a: assert property (
    (!bus.rd)
      |=> (rdata == 32'h0000_0000))
    else $error("Read data stood outside the cycle after a read.");

  ctrl_read_a: assert property (
    (bus.rd && bus.addr == mpt_pkg::CTRL_OFS)
      |=> (rdata == {31'h0000_0000, $past(test_q)}))
    else $error("Control register read returned wrong value.");

  rxp_read_a: assert property (
    (bus.rd && bus.addr == mpt_pkg::RXP_OFS)
      |=> (rdata == {16'h0000, $past(rxp_q)}))
    else $error("Receive pause timer read returned wrong value.");

  txp_read_a: assert property (
    (bus.rd && bus.addr == mpt_pkg::TXP_OFS)
      |=> (rdata == {16'h0000, $past(txp_q)}))
    else $error("Transmit pause timer read returned wrong value.");

  pace_write_a: assert property (
    (wr_pace && !tx_end.done)
      |=> (pace_q == $past(bus.wdata[4:0])))
    else $error("Pacing count write lost or upper bits taken.");

  rxp_locked_a: assert property (
    (!test_q && bus.wr && bus.addr == mpt_pkg::RXP_OFS && !pause_sent && !resend && !tick)
      |=> $stable(rxp_q))
    else $error("Receive pause timer written outside test mode.");

  txp_block_a: assert property (
    (txp_q != 16'h0000)
      |-> !tx_enable)
    else $error("Transmission enabled while transmit pause timer runs.");

  tx_resume_a: assert property (
    txp_last_tick_s
      |=> tx_enable)
    else $error("Transmission not enabled again when pause ended.");

  txp_floor_a: assert property (
    (tick && txp_q == 16'h0000 && !pause_rx.valid && !wr_txp)
      |=> (txp_q == 16'h0000))
    else $error("Transmit pause timer wrapped below zero.");

  gap_count_a: assert property (
    (!tx_end.done && gap_q != '0)
      |=> (gap_q == $past(gap_q) - GAP_W'(1)))
    else $error("Inter-packet gap counter missed a step.");

  gap_block_a: assert property (
    (gap_q != '0)
      |-> !tx_enable)
    else $error("Transmission enabled inside an inter-packet gap.");

  pace_hold_a: assert property (
    (!tx_end.done && !wr_pace)
      |=> $stable(pace_q))
    else $error("Pacing count moved without a frame or write.");

  resend_once_a: assert property (
    pause_resend
      |=> !pause_resend)
    else $error("Pause resend request lasted more than one cycle.");

  resend_gate_a: assert property (
    (!flow_active)
      |-> !pause_resend)
    else $error("Pause resend requested without flow control.");

  pace_active_a: assert property (
    dirty
      |=> pacing_active)
    else $error("Pacing not active after collision or deferral.");

endmodule

// [design/mpt_pkg.sv]
// Constants and carrier types of the transmit pacing and pause timer block.
// Assumes one 40 MHz clock and byte addresses on a plain register port.
package mpt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] PACE_OFS = 8'h00;
  localparam logic [7:0] RXP_OFS  = 8'h04;
  localparam logic [7:0] TXP_OFS  = 8'h08;
  localparam logic [7:0] CTRL_OFS = 8'h0C;

  localparam int PACE_W    = 5;
  localparam int PAUSE_W   = 16;
  localparam int PACE_LSB  = 0;
  localparam int PAUSE_LSB = 0;
  localparam int TEST_BIT  = 0;

  localparam logic [4:0]  PACE_MAX   = 5'h1F;
  localparam logic [15:0] RXP_RELOAD = 16'hFF00;
  localparam logic [4:0]  PACE_RST   = 5'h00;
  localparam logic [15:0] PAUSE_RST  = 16'h0000;
  localparam logic        CTRL_RST   = 1'b0;
  localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

  localparam int CLK_PERIOD_NS = 25;
  localparam int SLOT_TIME_NS  = 5120;
  localparam int SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int IPG_TIME_NS   = 960;
  localparam int IPG_CYCLES    = (IPG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PACE_GAP_MULT = 4;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mpt_bus_req_t;

  typedef struct packed {
    logic done;
    logic collided;
    logic deferred;
  } mpt_tx_end_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] quanta;
  } mpt_pause_rx_t;

endpackage

// [verif/mpt_link_model.sv]
// Model of the MAC side that feeds the timers: frame ends and pause frames.
// Assumes the bench calls its tasks from the timers' clock domain.
`timescale 1ns/1ps

module mpt_link_model (
  input  wire logic              clk,
  output mpt_pkg::mpt_tx_end_t   tx_end,
  output mpt_pkg::mpt_pause_rx_t pause_rx,
  output logic                   pause_sent
);
  initial begin
    tx_end = '0;
    pause_rx = '0;
    pause_sent = 1'b0;
  end

  // One transmit attempt ends, clean, collided or deferred.
  task automatic frame(input logic col, input logic dfr);
    @(posedge clk);
    tx_end <= '{done: 1'b1, collided: col, deferred: dfr};
    @(posedge clk);
    tx_end <= '0;
  endtask

  // An incoming pause frame carrying the given pause time.
  task automatic pause_in(input logic [15:0] q);
    @(posedge clk);
    pause_rx <= '{valid: 1'b1, quanta: q};
    @(posedge clk);
    pause_rx <= '0;
  endtask

  // The MAC reports an outgoing pause frame with maximum time.
  task automatic pause_out();
    @(posedge clk);
    pause_sent <= 1'b1;
    @(posedge clk);
    pause_sent <= 1'b0;
  endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the pacing counter and both pause timers.
// Assumes a shortened slot time and gap set through the timer parameters.
`timescale 1ns/1ps

module testbench;
  localparam int SLOT = 4;
  localparam int IPG  = 3;
  logic                   clk         = 1'b0;
  logic                   reset       = 1'b1;
  logic                   flow_active = 1'b0;
  mpt_pkg::mpt_bus_req_t  bus         = '0;
  mpt_pkg::mpt_tx_end_t   tx_end;
  mpt_pkg::mpt_pause_rx_t pause_rx;
  logic                   pause_sent;
  logic [31:0]            rdata;
  logic                   pause_resend;
  logic                   tx_enable;
  logic                   pacing_active;
  logic [31:0]            v;
  int                     error_cnt   = 0;
  int                     compares    = 0;
  int                     n;

  always #12.5 clk = ~clk;

  mpt_timers #(.SLOT_CYCLES(SLOT), .IPG_CYCLES(IPG)) dut_u (
    .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .tx_end(tx_end),
    .pause_rx(pause_rx), .pause_sent(pause_sent), .flow_active(flow_active),
    .pause_resend(pause_resend), .tx_enable(tx_enable), .pacing_active(pacing_active));

  mpt_link_model link_u (
    .clk(clk), .tx_end(tx_end), .pause_rx(pause_rx), .pause_sent(pause_sent));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask

  // Counts edges until the given signal is high, bounded.
  task automatic wait_high(input int sel, output int cnt);
    cnt = 0;
    #1;
    while ((sel == 0 ? tx_enable : pause_resend) !== 1'b1) begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 500) begin
        error_cnt++;
        end_of_test();
      end
    end
  endtask

  // Sends a frame, then checks the gap and the pacing count.
  task automatic frm(input logic col, input logic dfr, input int gap, input logic [31:0] pc);
    link_u.frame(col, dfr);
    wait_high(0, n);
    chk("gap", n, gap);
    rdv(mpt_pkg::PACE_OFS, v);
    chk("pacing", v, pc);
    chk("active", pacing_active, pc != 0);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdv(mpt_pkg::PACE_OFS, v);
    chk("pace rst", v, 32'h0000_0000);
    rdv(mpt_pkg::RXP_OFS, v);
    chk("rxp rst", v, 32'h0000_0000);
    rdv(mpt_pkg::TXP_OFS, v);
    chk("txp rst", v, 32'h0000_0000);
    chk("tx_enable rst", tx_enable, 1'b1);
    $display("reset test done");
    wr(mpt_pkg::PACE_OFS, 32'hFFFF_FFE1);
    rdv(mpt_pkg::PACE_OFS, v);
    chk("pace upper", v, 32'h0000_0001);
    frm(1'b0, 1'b0, 4 * IPG, 32'h0000_0000);
    frm(1'b0, 1'b0, IPG, 32'h0000_0000);
    frm(1'b1, 1'b0, IPG, 32'h0000_001F);
    frm(1'b0, 1'b0, 4 * IPG, 32'h0000_001E);
    frm(1'b0, 1'b1, IPG, 32'h0000_001F);
    $display("pacing test done");
    wr(mpt_pkg::RXP_OFS, 32'h0000_1234);
    rdv(mpt_pkg::RXP_OFS, v);
    chk("rxp locked", v, 32'h0000_0000);
    wr(mpt_pkg::CTRL_OFS, 32'h0000_0001);
    rdv(mpt_pkg::CTRL_OFS, v);
    chk("ctrl test", v, 32'h0000_0001);
    wr(mpt_pkg::TXP_OFS, 32'hABCD_0005);
    rdv(mpt_pkg::TXP_OFS, v);
    chk("txp write", v inside {32'h0000_0005, 32'h0000_0004}, 1'b1);
    wait_high(0, n);
    link_u.pause_in(16'h0006);
    wait_high(0, n);
    chk("txp hold", n inside {[5 * SLOT + 1 : 6 * SLOT]}, 1'b1);
    $display("transmit pause test done");
    @(posedge clk);
    flow_active <= 1'b1;
    link_u.pause_out();
    rdv(mpt_pkg::RXP_OFS, v);
    chk("rxp load", v inside {32'h0000_FF00, 32'h0000_FEFF}, 1'b1);
    wr(mpt_pkg::RXP_OFS, 32'h0000_0003);
    wait_high(1, n);
    chk("rxp count", n inside {[2 * SLOT + 1 : 3 * SLOT]}, 1'b1);
    rdv(mpt_pkg::RXP_OFS, v);
    chk("rxp reload", v, 32'h0000_FF00);
    @(posedge clk);
    flow_active <= 1'b0;
    $display("receive pause test done");
    end_of_test();
  end
endmodule
